// ### logic/dst_flag.sv
`timescale 1ns/100ps
`default_nettype none
module dst_flag
    import dst_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // set and clear
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);
    ////////////////////////////////////////////////////////////////////
    // sticky flag, set wins over clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clear_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule : dst_flag
`default_nettype wire

// ### logic/dst_lost_timer.sv
`timescale 1ns/100ps
`default_nettype none
module dst_lost_timer
    import dst_pkg::*;
#(
    parameter int CYCLES = BYTE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // request tracking
    input wire logic request_i,
    output logic overrun_o
);
    logic [15:0] count_ff;

    ////////////////////////////////////////////////////////////////////
    // counts how long a request stays unserviced
    always_ff @(posedge clk_i) begin
        if (reset_i || !request_i) begin
            count_ff <= 16'h0000;
            overrun_o <= 1'b0;
        end else begin
            overrun_o <= (count_ff == 16'(CYCLES - 1));
            if (count_ff != 16'(CYCLES - 1)) begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end
endmodule : dst_lost_timer
`default_nettype wire

// ### logic/dst_pkg.sv
package dst_pkg;

    // status bit positions
    localparam int BIT_NOT_READY = 7;
    localparam int BIT_WPROT = 6;
    localparam int BIT_RTYPE = 5;
    localparam int BIT_RNF = 4;
    localparam int BIT_CRC = 3;
    localparam int BIT_LOST = 2;
    localparam int BIT_DRQ = 1;
    localparam int BIT_BUSY = 0;

    // register map (word index on the plain port)
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_COMMAND = 2'h1;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // command codes written to the command register
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_READ_SECTOR = 2'h1;
    localparam logic [1:0] CMD_READ_TRACK = 2'h2;
    localparam logic [1:0] CMD_WRITE = 2'h3;

    // one byte time (32 us in double density)
    localparam int BYTE_TIME_NS = 32000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int BYTE_CYCLES = BYTE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } dst_state_type;

    // results reported by the data path at command end
    typedef struct packed {
        logic record_missing_flag;
        logic crc;
        logic deleted_mark;
        logic write_fault;
        logic write_protect;
    } dst_result_type;

    // drive status lines
    typedef struct packed {
        logic ready;
        logic write_protect;
        logic write_fault;
    } dst_drive_type;

endpackage : dst_pkg

// ### logic/dst_status.sv
// Function
// - bit 7 high when drive not ready or master reset asserted
// - read sector, read track and write refused while drive not ready
// - bit 6 flags write protect during writes, clears on update
// - bit 5 on read sector is mark type, 1 deleted, 0 normal
// - bit 5 on writes flags drive write fault, clears on update
// - bit 4 set when track, sector or side not found, except on read track
// - bit 3 flags crc error except on read track, id fields if bit 4 also set
// - host services request in one byte time, else bit 2 lost data
// - bit 1 mirrors the data request output
// - bit 0 high while a command executes
`timescale 1ns/100ps
`default_nettype none
module dst_status
    import dst_pkg::*;
#(
    parameter int BYTE_CYC = BYTE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // drive and master reset
    input wire logic master_reset_in_i,
    input wire dst_drive_type drive_i,
    // data path
    input wire logic byte_holding_register_full_i,
    input wire logic byte_serviced_i,
    input wire logic cmd_end_i,
    input wire dst_result_type result_i,
    // command outputs
    output logic transfer_request_out_o,
    output logic [1:0] active_cmd_o,
    output logic cmd_refused_o
);
    dst_state_type state_ff, nxt_state;
    logic [1:0] cmd_ff;
    logic [7:0] rdata_ff;
    logic drq_ff, nxt_drq;
    logic refused_ff;
    logic not_ready_ff;
    logic rtype_ff;
    logic is_write, is_rsec, busy;
    logic start_req, start_ok, start_bad, update;
    logic overrun;
    logic lost_flag, wprot_flag, wfault_flag, rnf_flag, crc_flag;
    logic [7:0] status_word;

    ////////////////////////////////////////////////////////////////////
    // decode
    assign start_req = wr_i && (addr_i == ADDR_COMMAND)
        && (wdata_i[1:0] != CMD_NONE) && (state_ff != ST_RUN);
    assign start_ok = start_req && drive_i.ready && !master_reset_in_i;
    assign start_bad = start_req && !start_ok;
    assign update = start_ok; // new command updates the status
    assign busy = (state_ff == ST_RUN);
    assign is_write = (cmd_ff == CMD_WRITE);
    assign is_rsec = (cmd_ff == CMD_READ_SECTOR);

    ////////////////////////////////////////////////////////////////////
    // command sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_ok) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cmd_end_i || master_reset_in_i) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (start_ok) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // data request: read full or write empty, only while running
    always_comb begin
        nxt_drq = 1'b0;
        if (busy && !cmd_end_i) begin
            nxt_drq = is_write ? !byte_holding_register_full_i
                               : byte_holding_register_full_i;
        end
        if (byte_serviced_i) begin
            nxt_drq = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky error flags
    dst_lost_timer #(.CYCLES(BYTE_CYC)) u_lost (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .request_i(drq_ff),
        .overrun_o(overrun)
    );

    dst_flag u_lost_flag (
        .clk_i(clk_i), .reset_i(reset_i),
        .set_i(overrun), .clear_i(update), .flag_o(lost_flag)
    );
    dst_flag u_wprot_flag (
        .clk_i(clk_i), .reset_i(reset_i),
        .set_i(busy && is_write && drive_i.write_protect),
        .clear_i(update), .flag_o(wprot_flag)
    );
    dst_flag u_wfault_flag (
        .clk_i(clk_i), .reset_i(reset_i),
        .set_i(busy && is_write && drive_i.write_fault),
        .clear_i(update), .flag_o(wfault_flag)
    );
    dst_flag u_rnf_flag (
        .clk_i(clk_i), .reset_i(reset_i),
        .set_i(busy && cmd_end_i && result_i.record_missing_flag
               && (cmd_ff != CMD_READ_TRACK)),
        .clear_i(update), .flag_o(rnf_flag)
    );
    dst_flag u_crc_flag (
        .clk_i(clk_i), .reset_i(reset_i),
        .set_i(busy && cmd_end_i && result_i.crc
               && (cmd_ff != CMD_READ_TRACK)),
        .clear_i(update), .flag_o(crc_flag)
    );

    ////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            cmd_ff <= CMD_NONE;
            drq_ff <= 1'b0;
            refused_ff <= 1'b0;
            not_ready_ff <= 1'b1;
            rtype_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            drq_ff <= nxt_drq;
            refused_ff <= start_bad;
            not_ready_ff <= !drive_i.ready || master_reset_in_i;
            if (start_ok) begin
                cmd_ff <= wdata_i[1:0];
            end
            if (update) begin
                rtype_ff <= 1'b0;
            end else if (busy && is_rsec && cmd_end_i) begin
                rtype_ff <= result_i.deleted_mark;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status assembly and read port
    assign status_word = {
        not_ready_ff,
        is_write ? wprot_flag : 1'b0,
        is_write ? wfault_flag : (is_rsec ? rtype_ff : 1'b0),
        rnf_flag,
        crc_flag,
        lost_flag,
        drq_ff,
        busy
    };

    // reads have no side effects on the command
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= STATUS_RESET;
        end else if (rd_i && addr_i == ADDR_STATUS) begin
            rdata_ff <= status_word;
        end else if (rd_i && addr_i == ADDR_COMMAND) begin
            rdata_ff <= {6'h00, cmd_ff};
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata_o = rdata_ff;
    assign transfer_request_out_o = drq_ff;
    assign active_cmd_o = cmd_ff;
    assign cmd_refused_o = refused_ff;
endmodule : dst_status
`default_nettype wire

// ### test/dst_host.sv
`timescale 1ns/100ps
`default_nettype none
module dst_host (
    // clock
    input wire logic clk_i,
    // data request handshake
    input wire logic request_i,
    input wire logic stall_i,
    output logic serviced_o,
    // register port master
    output logic [1:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i
);
    // bus idle at time zero
    initial begin
        {addr_o, wdata_o, wr_o, rd_o, serviced_o} = '0;
    end
    // move one byte per request unless the bench holds the host off
    always @(posedge clk_i) begin
        serviced_o <= request_i && !stall_i && !serviced_o;
    end
    // one-cycle write strobe, then a quiet cycle
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        @(posedge clk_i);
    endtask : wr_reg
    // read strobe, data taken in the cycle after it
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 v = rdata_i;
        @(posedge clk_i);
    endtask : rd_reg
endmodule : dst_host
`default_nettype wire

// ### test/dst_status_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dst_status_properties
    import dst_pkg::*;
#(
    parameter int BYTE_CYC = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // drive and data path
    input wire logic master_reset_in_i,
    input wire dst_drive_type drive_i,
    input wire logic byte_holding_register_full_i,
    input wire logic byte_serviced_i,
    input wire logic cmd_end_i,
    input wire dst_result_type result_i,
    // command outputs
    input wire logic transfer_request_out_o,
    input wire logic [1:0] active_cmd_o,
    input wire logic cmd_refused_o
);
    // decoded strobes and the blocking condition
    wire logic cmd_wr = wr_i && addr_i == ADDR_COMMAND && wdata_i[1:0] != 2'h0;
    wire logic st_rd = rd_i && addr_i == ADDR_STATUS;
    wire logic blocked = !drive_i.ready || master_reset_in_i;
    logic busy_m;
    // reference busy: set by an accepted command, cleared by end or reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_m <= 1'b0;
        end else if (busy_m && (cmd_end_i || master_reset_in_i)) begin
            busy_m <= 1'b0;
        end else if (!busy_m && cmd_wr && !blocked) begin
            busy_m <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////
    chk_refuse_blocked: assert property (cmd_wr && blocked && !busy_m
        |=> cmd_refused_o) else $error("no refusal");
    chk_start_cmd: assert property (cmd_wr && !blocked && !busy_m
        |=> active_cmd_o == $past(wdata_i[1:0]) && !cmd_refused_o)
        else $error("command not started");
    chk_busy_held: assert property (busy_m
        |=> $stable(active_cmd_o)) else $error("busy lost");
    chk_end_idle: assert property (busy_m && cmd_end_i ##1 st_rd
        |=> !rdata_o[BIT_BUSY]) else $error("busy after end");
    chk_reset_abort: assert property (busy_m && master_reset_in_i ##1 st_rd
        |=> !rdata_o[BIT_BUSY] && rdata_o[BIT_NOT_READY])
        else $error("busy under reset");
    chk_not_ready_bit: assert property (st_rd && !$past(reset_i)
        && $stable(blocked) |=> rdata_o[BIT_NOT_READY] == $past(blocked))
        else $error("bit 7 wrong");
    chk_busy_bit: assert property (st_rd
        |=> rdata_o[BIT_BUSY] == $past(busy_m))
        else $error("bit 0 wrong");
    chk_drq_bit: assert property (st_rd && $stable(transfer_request_out_o)
        |=> rdata_o[BIT_DRQ] == $past(transfer_request_out_o))
        else $error("bit 1 wrong");
    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data without read");
endmodule : dst_status_properties

bind dst_status dst_status_properties #(.BYTE_CYC(BYTE_CYC)) u_props (.*);
`default_nettype wire

// ### test/tb_dst_status.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dst_status;
    import dst_pkg::*;
    logic clk_i, reset_i, mr, full, cmd_end, stall, srv, wr, rd, transfer_request_out, refused;
    logic [1:0] addr, act;
    logic [7:0] wdata, rdata, d;
    dst_drive_type drive;
    dst_result_type res;
    int failures, n_compared;
    // rows: command, data-path result, final status with bit 1 masked
    logic [14:0] rows [6] = '{{CMD_READ_SECTOR, 5'b11100, 8'h38},
        {CMD_WRITE, 5'b11011, 8'h78}, {CMD_READ_SECTOR, 5'b00000, 8'h00},
        {CMD_READ_SECTOR, 5'b00111, 8'h20}, {CMD_READ_TRACK, 5'b00000, 8'h00},
        {CMD_WRITE, 5'b00100, 8'h00}};
    dst_status #(.BYTE_CYC(8)) dut (.clk_i(clk_i), .reset_i(reset_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .master_reset_in_i(mr), .drive_i(drive),
        .byte_holding_register_full_i(full), .byte_serviced_i(srv),
        .cmd_end_i(cmd_end), .result_i(res), .transfer_request_out_o(transfer_request_out),
        .active_cmd_o(act), .cmd_refused_o(refused));
    dst_host host (.clk_i(clk_i), .request_i(transfer_request_out), .stall_i(stall),
        .serviced_o(srv), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // start a command and look at the fresh status while it runs
    task automatic start(input logic [1:0] c);
        host.wr_reg(ADDR_COMMAND, {6'h00, c});
        host.rd_reg(ADDR_STATUS, d);
        check("busy", d & 8'hfd, 8'h01);
        check("cmd", {6'h00, act}, {6'h00, c});
    endtask : start
    // end the command with a result and read the final status
    task automatic fin(input dst_result_type r, input logic [7:0] e);
        cmd_end <= 1'b1;
        res <= r;
        drive.write_protect <= r.write_protect;
        drive.write_fault <= r.write_fault;
        @(posedge clk_i);
        cmd_end <= 1'b0;
        drive.write_protect <= 1'b0;
        drive.write_fault <= 1'b0;
        host.rd_reg(ADDR_STATUS, d);
        check("final", d & 8'hfd, e);
    endtask : fin
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        end_sim();
    end
    // main sequence
    initial begin
        {reset_i, mr, full, cmd_end, stall} = 5'b10000;
        drive = 3'b100;
        res = '0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        host.rd_reg(ADDR_STATUS, d);
        check("reset", d & 8'hfd, STATUS_RESET);
        host.rd_reg(2'h2, d);
        check("unmapped", d, 8'h00);
        foreach (rows[i]) begin
            start(rows[i][14:13]);
            fin(rows[i][12:8], rows[i][7:0]);
            $display("row %0d done", i);
        end
        // host stalls past one byte time
        stall <= 1'b1;
        full <= 1'b1;
        start(CMD_READ_TRACK);
        repeat (12) @(posedge clk_i);
        host.rd_reg(ADDR_STATUS, d);
        check("lost", d & 8'hfd, 8'h05);
        stall <= 1'b0;
        full <= 1'b0;
        fin('0, 8'h04);
        $display("lost data done");
        // not ready, then master reset, each refuse a command
        for (int k = 0; k < 2; k++) begin
            drive.ready <= k[0];
            mr <= k[0];
            repeat (2) @(posedge clk_i);
            host.wr_reg(ADDR_COMMAND, {6'h00, CMD_WRITE});
            host.rd_reg(ADDR_STATUS, d);
            check("refused", d & 8'hfd, 8'h84);
        end
        $display("refusal done");
        end_sim();
    end
endmodule : tb_dst_status
`default_nettype wire
